// >>> hw/core_supply_pkg.sv
// constants and states for the external core supply control block
// assumes a single 250 MHz clock shared by all users of this package
package core_supply_pkg;

   // clock period and counter width
   localparam int CLK_PERIOD_NS = 4;
   localparam int CNT_W = 32;

   // spike filter: an excursion must last at least this long to count
   localparam int RR_TIME_NS = 10000;
   localparam logic [31:0] RR_CYCLES =
      32'((RR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // default figures for the long timers, overridable at the top
   localparam int STG_TIME_NS_DEF = 4000000;
   localparam int RESET_DELAY_NS_DEF = 10000000;

   // reset values of the enable, reset and sync outputs
   localparam logic ENABLE_RST = 1'b0;
   localparam logic RESET_OUT_RST = 1'b0;
   localparam logic SYNC_RST = 1'b0;

   // level of the option pin when left open (internal pull-up)
   localparam logic OPTION_OPEN_LEVEL = 1'b1;

   // sequencing states
   typedef enum logic [2:0]
   {
      st_power_up,
      st_core_wait,
      st_reset_delay,
      st_normal,
      st_safe_shutdown
   } state_t;

endpackage

// >>> hw/ext_core_supply_control.sv
// sequencing, monitoring and sync output for an external core post regulator
// assumes analog comparators and the option pin arrive asynchronously,
// while spi settings and the pre-regulator phase come from clk logic
`timescale 1ns/1ps
module ext_core_supply_control
#(
   parameter int STG_TIME_NS = core_supply_pkg::STG_TIME_NS_DEF,
   parameter int RESET_DELAY_NS = core_supply_pkg::RESET_DELAY_NS_DEF
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // board pins and comparators (asynchronous)
   input wire logic core_option_select_pin,
   input wire logic prereg_present,
   input wire logic micro_ldo_above_low,
   input wire logic core_voltage_monitor_in_under,
   input wire logic core_voltage_monitor_in_over,
   // pre-regulator switching phase (clk domain)
   input wire logic prereg_phase,
   // spi settings and flag clears (clk domain)
   input wire logic sync_enable,
   input wire logic sync_invert,
   input wire logic [1:0] reset_delay_sel,
   input wire logic clear_ground_short,
   input wire logic clear_over_voltage,
   input wire logic clear_under_voltage,
   // outputs
   output logic post_reg_enable_out,
   output logic switching_sync_out,
   output logic reset_output,
   output logic vref_ldo_enable,
   output logic core_option_active,
   output logic ground_short_flags,
   output logic over_voltage_flags,
   output logic under_voltage_flags
);

   // long counts derived from the top-level times
   localparam logic [31:0] STG_CYCLES =
      32'((STG_TIME_NS + core_supply_pkg::CLK_PERIOD_NS - 1) / core_supply_pkg::CLK_PERIOD_NS);
   localparam logic [31:0] RD_CYCLES =
      32'((RESET_DELAY_NS + core_supply_pkg::CLK_PERIOD_NS - 1) / core_supply_pkg::CLK_PERIOD_NS);

   logic [4:0] pin_meta;
   logic [4:0] pin_sync;
   logic opt_s, pre_s, micro_s, under_s, over_s;
   core_supply_pkg::state_t state, next_state;
   logic next_enable, next_reset, next_vref, next_ext, next_sync;
   logic next_gs_flag, next_ov_flag, next_uv_flag;
   logic [31:0] ov_cnt, next_ov_cnt, uv_cnt, next_uv_cnt, stg_cnt, next_stg_cnt;
   logic [31:0] delay_cnt, next_delay_cnt, delay_target;
   logic monitor_on, ov_det, uv_det, stg_det;

   // two-stage synchroniser for all asynchronous inputs
   always_ff @(posedge clk)
   begin
      pin_meta <= {core_option_select_pin, prereg_present, micro_ldo_above_low,
                   core_voltage_monitor_in_under, core_voltage_monitor_in_over};
      pin_sync <= pin_meta;
   end

   assign {opt_s, pre_s, micro_s, under_s, over_s} = pin_sync;

   // monitor only while the external regulator is in use
   assign monitor_on = core_option_active && post_reg_enable_out;
   assign ov_det = ov_cnt >= core_supply_pkg::RR_CYCLES;
   assign uv_det = uv_cnt >= core_supply_pkg::RR_CYCLES;
   assign stg_det = stg_cnt >= STG_CYCLES;
   assign delay_target = 32'(RD_CYCLES * ({30'h0, reset_delay_sel} + 32'h1));

   // next-state logic for sequencing, monitoring and flags
   always_comb
   begin
      next_state = state;
      next_enable = post_reg_enable_out;
      next_reset = reset_output;
      next_vref = vref_ldo_enable;
      next_ext = core_option_active;
      next_delay_cnt = delay_cnt;
      // saturating persistence counters, cleared on any gap
      next_ov_cnt = (over_s && monitor_on) ? (ov_det ? ov_cnt : ov_cnt + 32'h1) : 32'h0;
      next_uv_cnt = (under_s && monitor_on) ? (uv_det ? uv_cnt : uv_cnt + 32'h1) : 32'h0;
      next_stg_cnt = (under_s && monitor_on) ? (stg_det ? stg_cnt : stg_cnt + 32'h1) : 32'h0;
      // sticky flags; a new event beats a clear
      next_gs_flag = ground_short_flags && !clear_ground_short;
      next_ov_flag = over_voltage_flags && !clear_over_voltage;
      next_uv_flag = under_voltage_flags && !clear_under_voltage;
      case (state)
         core_supply_pkg::st_power_up:
         begin
            // wait for prereg and micro ldo
            if (pre_s && micro_s)
            begin
               // the only place the option pin is read
               // open pin selects the external option
               next_ext = (opt_s == core_supply_pkg::OPTION_OPEN_LEVEL);
               if (opt_s == core_supply_pkg::OPTION_OPEN_LEVEL)
               begin
                  next_enable = 1'b1;
                  next_state = core_supply_pkg::st_core_wait;
               end
               else
               begin
                  // no option: reference starts at once
                  next_vref = 1'b1;
                  next_delay_cnt = 32'h0;
                  next_state = core_supply_pkg::st_reset_delay;
               end
            end
         end
         core_supply_pkg::st_core_wait:
         begin
            // reference waits for core above low threshold
            if (!under_s)
            begin
               next_vref = 1'b1;
               next_delay_cnt = 32'h0;
               next_state = core_supply_pkg::st_reset_delay;
            end
         end
         core_supply_pkg::st_reset_delay:
         begin
            // release reset when the delay expires
            if (delay_cnt >= delay_target - 32'h1)
            begin
               next_reset = 1'b1;
               next_state = core_supply_pkg::st_normal;
            end
            else
            begin
               next_delay_cnt = delay_cnt + 32'h1;
            end
         end
         core_supply_pkg::st_normal:
         begin
            next_state = core_supply_pkg::st_normal;
         end
         default:
         begin
            // safe shutdown holds enable, reference and reset off until reset
            next_enable = 1'b0;
            next_vref = 1'b0;
            next_reset = 1'b0;
         end
      endcase
      if (state != core_supply_pkg::st_safe_shutdown)
      begin
         if (ov_det || stg_det)
         begin
            // persistent under-voltage is a ground short
            next_state = core_supply_pkg::st_safe_shutdown;
            next_enable = 1'b0;
            next_vref = 1'b0;
            next_reset = 1'b0;
            next_ov_flag = next_ov_flag || ov_det;
            next_gs_flag = next_gs_flag || stg_det;
            next_uv_flag = next_uv_flag || uv_det;
         end
         else if (uv_det)
         begin
            // short under-voltage: back to startup, regulator stays on
            next_uv_flag = 1'b1;
            if (state == core_supply_pkg::st_reset_delay || state == core_supply_pkg::st_normal)
            begin
               next_state = core_supply_pkg::st_core_wait;
               next_reset = 1'b0;
            end
         end
      end
      // sync follows prereg phase, optionally inverted
      next_sync = sync_enable && (prereg_phase ^ sync_invert);
   end

   // state registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state <= core_supply_pkg::st_power_up;
         post_reg_enable_out <= core_supply_pkg::ENABLE_RST;
         reset_output <= core_supply_pkg::RESET_OUT_RST;
         vref_ldo_enable <= 1'b0;
         core_option_active <= 1'b0;
         switching_sync_out <= core_supply_pkg::SYNC_RST;
         ground_short_flags <= 1'b0;
         over_voltage_flags <= 1'b0;
         under_voltage_flags <= 1'b0;
         ov_cnt <= 32'h0;
         uv_cnt <= 32'h0;
         stg_cnt <= 32'h0;
         delay_cnt <= 32'h0;
      end
      else
      begin
         state <= next_state;
         post_reg_enable_out <= next_enable;
         reset_output <= next_reset;
         vref_ldo_enable <= next_vref;
         core_option_active <= next_ext;
         switching_sync_out <= next_sync;
         ground_short_flags <= next_gs_flag;
         over_voltage_flags <= next_ov_flag;
         under_voltage_flags <= next_uv_flag;
         ov_cnt <= next_ov_cnt;
         uv_cnt <= next_uv_cnt;
         stg_cnt <= next_stg_cnt;
         delay_cnt <= next_delay_cnt;
      end
   end

   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   sequence start_ok_s;
      state == core_supply_pkg::st_power_up && pre_s && micro_s;
   endsequence

   sequence ov_hit_s;
      ov_det && state != core_supply_pkg::st_safe_shutdown;
   endsequence

   // compare with the pin as it stood at the start step, not one cycle later
   option_select_a: assert property (start_ok_s |=> core_option_active
      == ($past(opt_s) == core_supply_pkg::OPTION_OPEN_LEVEL))
      else $error("option not taken from open pin");
   option_hold_a: assert property (state != core_supply_pkg::st_power_up |=> $stable(core_option_active))
      else $error("option changed outside start step");
   enable_on_a: assert property (start_ok_s ##0 opt_s == core_supply_pkg::OPTION_OPEN_LEVEL
      |=> post_reg_enable_out)
      else $error("enable not raised at start");
   enable_off_a: assert property (ov_hit_s |=> !post_reg_enable_out && over_voltage_flags
      && state == core_supply_pkg::st_safe_shutdown)
      else $error("over-voltage not handled");
   uv_startup_a: assert property (uv_det && !stg_det && !ov_det && state == core_supply_pkg::st_normal
      |=> !reset_output && under_voltage_flags && post_reg_enable_out)
      else $error("under-voltage not handled");
   stg_a: assert property ($rose(ground_short_flags) |-> $past(stg_cnt) >= STG_CYCLES)
      else $error("ground short flagged too early");
   spike_a: assert property ($rose(over_voltage_flags) |-> $past(ov_cnt) >= core_supply_pkg::RR_CYCLES)
      else $error("over-voltage flagged before reaction time");
   vref_wait_a: assert property ($rose(vref_ldo_enable) && core_option_active |-> $past(!under_s))
      else $error("reference started before core up");
   reset_rel_a: assert property ($rose(reset_output) |-> $past(state) == core_supply_pkg::st_reset_delay
      && $past(delay_cnt) >= $past(delay_target) - 32'h1)
      else $error("reset released early");
   sync_off_a: assert property (!$past(sync_enable) |-> !switching_sync_out)
      else $error("sync toggles while disabled");
   // the edge that leaves reset loads the reset value, whatever the enable
   sync_phase_a: assert property (!$past(rst) && $past(sync_enable) |->
      switching_sync_out == ($past(prereg_phase) ^ $past(sync_invert)))
      else $error("sync phase wrong");
   flag_hold_a: assert property (over_voltage_flags && !clear_over_voltage |=> over_voltage_flags)
      else $error("flag lost without clear");
   enable_state_a: assert property (state == core_supply_pkg::st_safe_shutdown |=> !post_reg_enable_out)
      else $error("enable high in shutdown");

endmodule

// >>> tb/post_reg_model.sv
// behavioural external post regulator driven by the block's enable
// assumes fault requests come from the bench on clk edges
`timescale 1ns/1ps
module post_reg_model
(
   // clock
   input wire logic clk,
   // enable from the block, faults from the bench
   input wire logic enable,
   input wire logic force_under,
   input wire logic force_over,
   // monitor comparator levels
   output logic under,
   output logic over
);
   logic [3:0] ramp = 4'h0;
   // follows enable level
   // output needs a few cycles to ramp, so the block never sees instant power
   always_ff @(posedge clk)
   begin
      ramp <= enable ? {ramp[2:0], 1'b1} : 4'h0;
   end
   // a switched-off regulator reads as under-voltage
   assign under = !ramp[3] | force_under;
   assign over = ramp[3] & force_over;
endmodule

// >>> tb/ext_core_supply_control_tb.sv
// self-checking bench for the external core supply control block
// assumes reaction time of 2500 cycles; timers shortened by parameters
`timescale 1ns/1ps
module ext_core_supply_control_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pin = 1'b1, pre = 1'b0, ldo = 1'b0, phase = 1'b0, sen = 1'b0, sinv = 1'b0;
   logic clr_gs = 1'b0, clr_ov = 1'b0, clr_uv = 1'b0, fu = 1'b0, fo = 1'b0, ph_q = 1'b0;
   logic under, over, en, sync, rout, vref, act, gs, ov, uv;
   logic [1:0] dsel = 2'h0;
   // one delay step: 200 ns at 4 ns per cycle
   localparam int RD_STEP = 50;
   int error_cnt = 0, check_count = 0, cyc = 0;
   // ground-short 5000 cycles so it outlasts the reaction time; delay 50
   ext_core_supply_control #(.STG_TIME_NS(20000), .RESET_DELAY_NS(200)) i_ext_core_supply_control
   (
      .clk(clk), .rst(rst), .core_option_select_pin(pin), .prereg_present(pre),
      .micro_ldo_above_low(ldo), .core_voltage_monitor_in_under(under),
      .core_voltage_monitor_in_over(over), .prereg_phase(phase), .sync_enable(sen),
      .sync_invert(sinv), .reset_delay_sel(dsel), .clear_ground_short(clr_gs),
      .clear_over_voltage(clr_ov), .clear_under_voltage(clr_uv),
      .post_reg_enable_out(en), .switching_sync_out(sync), .reset_output(rout),
      .vref_ldo_enable(vref), .core_option_active(act), .ground_short_flags(gs),
      .over_voltage_flags(ov), .under_voltage_flags(uv)
   );
   post_reg_model i_post_reg_model
   (
      .clk(clk), .enable(en), .force_under(fu), .force_over(fo), .under(under), .over(over)
   );
   always #2 clk = ~clk;
   // pre-regulator phase, 50% square wave; timeout ceiling
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      ph_q <= phase;
      if (cyc % 4 == 3)
         phase <= ~phase;
      if (cyc == 40000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   task automatic chk(input string name, input logic seen, input logic exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
   endtask
   // checks land mid-cycle, clear of edge updates
   task automatic settle();
      @(negedge clk);
   endtask
   // one-cycle clear pulse; mask bits are ground, over, under
   task automatic pulse(input logic [2:0] m);
      {clr_gs, clr_ov, clr_uv} <= m;
      cyc_n(1);
      {clr_gs, clr_ov, clr_uv} <= 3'h0;
      cyc_n(2);
   endtask
   // reset then power up with option pin level p and delay select d
   task automatic restart(input logic p, input logic [1:0] d);
      rst <= 1'b1;
      pin <= p;
      dsel <= d;
      {pre, ldo, fu, fo} <= 4'h0;
      cyc_n(3);
      rst <= 1'b0;
      cyc_n(2);
      settle();
      chk("enable after reset", en, 1'b0);
      @(posedge clk);
      pre <= 1'b1;
      ldo <= 1'b1;
      cyc_n(5);
      settle();
      chk("enable", en, p);
      chk("option", act, p);
      chk("vref early", vref, !p);
      cyc_n(10);
      settle();
      chk("vref", vref, 1'b1);
      chk("reset held", rout, 1'b0);
      cyc_n(60);
      settle();
      // a longer select must still hold reset here
      chk("reset released", rout, d == 2'h0);
      if (d != 2'h0)
      begin
         cyc_n(RD_STEP * d);
         settle();
         chk("reset released late", rout, 1'b1);
      end
      @(posedge clk);
   endtask
   task automatic sync_test();
      settle();
      repeat (8)
      begin
         @(negedge clk);
         chk("sync off", sync, 1'b0);
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         sinv <= i[0];
         sen <= 1'b1;
         cyc_n(2);
         repeat (12)
         begin
            @(negedge clk);
            chk("sync", sync, ph_q ^ i[0]);
         end
      end
      @(posedge clk);
      sen <= 1'b0;
   endtask
   task automatic mon_test();
      fu <= 1'b1;
      cyc_n(2000);
      fu <= 1'b0;
      cyc_n(10);
      settle();
      chk("spike flag", uv, 1'b0);
      chk("spike reset", rout, 1'b1);
      @(posedge clk);
      fu <= 1'b1;
      cyc_n(2600);
      settle();
      chk("under flag", uv, 1'b1);
      chk("under reset", rout, 1'b0);
      chk("under enable", en, 1'b1);
      @(posedge clk);
      fu <= 1'b0;
      cyc_n(80);
      settle();
      chk("under sticky", uv, 1'b1);
      chk("reset again", rout, 1'b1);
      @(posedge clk);
      pulse(3'h1);
      settle();
      chk("under cleared", uv, 1'b0);
      @(posedge clk);
      fo <= 1'b1;
      cyc_n(2600);
      fo <= 1'b0;
      cyc_n(10);
      settle();
      chk("over enable", en, 1'b0);
      chk("over flag", ov, 1'b1);
      @(posedge clk);
      pulse(3'h2);
      settle();
      chk("over cleared", ov, 1'b0);
      chk("shutdown holds", en, 1'b0);
      @(posedge clk);
   endtask
   task automatic gs_test();
      fu <= 1'b1;
      cyc_n(5200);
      fu <= 1'b0;
      settle();
      chk("ground flag", gs, 1'b1);
      chk("ground enable", en, 1'b0);
      @(posedge clk);
      pulse(3'h4);
      settle();
      chk("ground cleared", gs, 1'b0);
      @(posedge clk);
   endtask
   // option pin moves after the start step and must be ignored
   task automatic pin_test();
      pin <= 1'b1;
      cyc_n(6);
      settle();
      chk("pin ignored", act, 1'b0);
      chk("no enable", en, 1'b0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      restart(1'b1, 2'h0);
      sync_test();
      mon_test();
      restart(1'b1, 2'h0);
      gs_test();
      restart(1'b0, 2'h1);
      pin_test();
      report_and_stop();
   end
endmodule
